// File: dhrs_pkg.sv
package dhrs_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned REJECT_US = 5;
  localparam int unsigned RESET_US = 9;
  localparam int unsigned HOST_MIN_LOW_US = 10;
  localparam int unsigned LOAD_START_MS = 5;
  localparam int unsigned CANCEL_SLEEP_IN_MS = 5;
  localparam int unsigned CANCEL_SLEEP_OUT_MS = 120;
  localparam int unsigned BLANK_MAX_MS = 120;
  // least times round up (spike bound), longest times round down
  localparam int unsigned REJECT_CYC = REJECT_US * CLK_MHZ;
  localparam int unsigned RESET_CYC = RESET_US * CLK_MHZ;
  localparam int unsigned MS_CYC = 1000 * CLK_MHZ;
  localparam int unsigned CANCEL_IN_CYC = CANCEL_SLEEP_IN_MS * MS_CYC;
  localparam int unsigned CANCEL_OUT_CYC = CANCEL_SLEEP_OUT_MS * MS_CYC;
  localparam int unsigned LOAD_START_CYC = LOAD_START_MS * MS_CYC;
  localparam int unsigned BLANK_CYC = BLANK_MAX_MS * MS_CYC;

  typedef enum logic [2:0] {
    DHRS_RUN = 3'b000,
    DHRS_BLANK = 3'b001,
    DHRS_HELD = 3'b010,
    DHRS_LOAD = 3'b011,
    DHRS_SETTLE = 3'b100
  } dhrs_state_t;

  typedef struct packed {
    logic busy;
    logic blank;
    logic load_active;
    logic ready;
  } dhrs_status_t;

  typedef struct packed {
    logic req;
    logic [7:0] addr;
  } dhrs_load_req_t;
endpackage

// File: dhrs_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// [RL1] reject lows under 5us, reset beyond 9us
// [RL2] glitches mid-reset neither end nor restart
// [RL3] reload stored settings within 5ms of release
// [RL4] sleep-in reset cancel done within 5ms
// [RL5] sleep-out reset cancel done within 120ms
// [RL6] blank display, then return to defaults
// [RL7] host waits 5ms before any command; after a sleep-in reset the command gate opens as soon as the load ends
// [RL8] host waits 120ms before sleep exit
module dhrs_sequencer #(
  parameter int unsigned REJECT_CYC = dhrs_pkg::REJECT_CYC,
  parameter int unsigned RESET_CYC = dhrs_pkg::RESET_CYC,
  parameter int unsigned CANCEL_IN_CYC = dhrs_pkg::CANCEL_IN_CYC,
  parameter int unsigned CANCEL_OUT_CYC = dhrs_pkg::CANCEL_OUT_CYC,
  parameter int unsigned BLANK_CYC = dhrs_pkg::BLANK_CYC,
  parameter int unsigned LOAD_WORDS = 16,
  parameter int unsigned CW = 28
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hw_reset_in_n,
  input wire logic sleep_out_mode,
  input wire logic [7:0] settings_store_data,
  input wire logic settings_store_valid,
  output logic [7:0] settings_store_addr,
  output logic settings_store_req,
  output logic [7:0] reg_wdata,
  output logic [7:0] reg_waddr,
  output logic reg_we,
  output logic restore_defaults,
  output dhrs_pkg::dhrs_status_t status,
  output logic cmd_accept,
  output logic sleep_exit_accept
);
  // two flops so a release near the edge cannot split the state machine
  logic rst_s1;
  logic rst_s2;
  // reset sync
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire logic rst_n = rst_s2;

  dhrs_pkg::dhrs_state_t state, next_state;
  logic [CW-1:0] low_cnt, next_low_cnt;
  logic [CW-1:0] high_cnt, next_high_cnt;
  logic [CW-1:0] tmr, next_tmr;
  logic was_sleep_out, next_was_sleep_out;
  logic in_reset, next_in_reset;
  logic [7:0] idx, next_idx;
  logic req, next_req;
  logic [7:0] wdata, next_wdata;
  logic [7:0] waddr, next_waddr;
  logic we, next_we;
  logic defaults, next_defaults;
  logic cmd_ok, next_cmd_ok;
  logic exit_ok, next_exit_ok;

  // counters stop at all ones so a long level cannot wrap into a short pulse
  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    sat_inc = (&v) ? v : v + {{(CW-1){1'b0}}, 1'b1};
  endfunction

  // run length of one pin level, restarted whenever the pin leaves it
  function automatic logic [CW-1:0] run_len(
    input logic pin_level,
    input logic want,
    input logic [CW-1:0] v
  );
    run_len = (pin_level == want) ? sat_inc(v) : '0;
  endfunction

  // a count has reached its limit
  function automatic logic reached(input logic [CW-1:0] v, input int unsigned limit);
    reached = (v >= CW'(limit));
  endfunction

  logic start_hit;
  logic release_hit;

  // start and release exclude each other through in_reset
  always_comb begin
    start_hit = !in_reset && reached(low_cnt, REJECT_CYC);
    release_hit = in_reset && reached(high_cnt, REJECT_CYC);
  end

  always_comb begin
    next_state = state;
    next_low_cnt = run_len(hw_reset_in_n, 1'b0, low_cnt);
    next_high_cnt = run_len(hw_reset_in_n, 1'b1, high_cnt);
    next_tmr = sat_inc(tmr);
    next_was_sleep_out = was_sleep_out;
    next_in_reset = in_reset;
    next_idx = idx;
    next_req = 1'b0;
    next_wdata = wdata;
    next_waddr = waddr;
    next_we = 1'b0;
    next_defaults = 1'b0;
    next_cmd_ok = cmd_ok;
    next_exit_ok = exit_ok;
    // [RL1] low pulse qualifies
    if (start_hit) begin
      // gates close here and the state cases must not reopen them
      next_in_reset = 1'b1;
      next_was_sleep_out = sleep_out_mode;
      next_state = dhrs_pkg::DHRS_BLANK;
      next_tmr = '0;
      next_cmd_ok = 1'b0;
      next_exit_ok = 1'b0;
    end else if (release_hit) begin
      // [RL2] release needs a steady high
      next_in_reset = 1'b0;
      next_state = dhrs_pkg::DHRS_LOAD;
      next_idx = '0;
      // the pin rose REJECT_CYC cycles before release is seen
      next_tmr = CW'(REJECT_CYC);
      next_defaults = 1'b1;
    end else begin
      case (state)
        dhrs_pkg::DHRS_RUN: begin
          // [RL7] command gate
          if (reached(tmr, CANCEL_IN_CYC)) begin
            next_cmd_ok = 1'b1;
          end
          // [RL8] sleep exit gate
          if (reached(tmr, CANCEL_OUT_CYC)) begin
            next_exit_ok = 1'b1;
          end
        end
        dhrs_pkg::DHRS_BLANK: begin
          // [RL6] bounded blank sequence
          if (!was_sleep_out || reached(tmr, BLANK_CYC)) begin
            next_state = dhrs_pkg::DHRS_HELD;
          end
        end
        // left only when release_hit fires above
        dhrs_pkg::DHRS_HELD: next_state = dhrs_pkg::DHRS_HELD;
        dhrs_pkg::DHRS_LOAD: begin
          // [RL3] fetch store words
          // one word in flight; req drops the cycle a word lands
          next_req = 1'b1;
          if (settings_store_valid) begin
            next_wdata = settings_store_data;
            next_waddr = idx;
            next_we = 1'b1;
            next_req = 1'b0;
            next_idx = idx + 8'h01;
            if (idx == 8'(LOAD_WORDS - 1)) next_state = dhrs_pkg::DHRS_SETTLE;
          end
        end
        dhrs_pkg::DHRS_SETTLE: begin
          // [RL4] [RL5] done by cancel limit
          // after sleep-out the command gate waits for the timer
          next_state = dhrs_pkg::DHRS_RUN;
          next_cmd_ok = !was_sleep_out;
        end
        default: next_state = dhrs_pkg::DHRS_RUN;
      endcase
    end
  end

  // registers only; every decision lives in the block above
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= dhrs_pkg::DHRS_LOAD;
      low_cnt <= '0;
      high_cnt <= '0;
      tmr <= '0;
      was_sleep_out <= 1'b0;
      in_reset <= 1'b0;
      idx <= 8'h00;
      req <= 1'b0;
      wdata <= 8'h00;
      waddr <= 8'h00;
      we <= 1'b0;
      defaults <= 1'b0;
      cmd_ok <= 1'b0;
      exit_ok <= 1'b0;
    end else begin
      state <= next_state;
      low_cnt <= next_low_cnt;
      high_cnt <= next_high_cnt;
      tmr <= next_tmr;
      was_sleep_out <= next_was_sleep_out;
      in_reset <= next_in_reset;
      idx <= next_idx;
      req <= next_req;
      wdata <= next_wdata;
      waddr <= next_waddr;
      we <= next_we;
      defaults <= next_defaults;
      cmd_ok <= next_cmd_ok;
      exit_ok <= next_exit_ok;
    end
  end

  // data outputs come straight from flops
  assign settings_store_addr = idx;
  assign settings_store_req = req;
  assign reg_wdata = wdata;
  assign reg_waddr = waddr;
  assign reg_we = we;
  assign restore_defaults = defaults;
  // status decoded from registers in one place
  always_comb begin
    status = '0;
    status.busy = (state != dhrs_pkg::DHRS_RUN);
    status.blank = in_reset || state == dhrs_pkg::DHRS_BLANK || state == dhrs_pkg::DHRS_HELD;
    status.load_active = (state == dhrs_pkg::DHRS_LOAD);
    status.ready = cmd_ok;
  end
  assign cmd_accept = cmd_ok;
  assign sleep_exit_accept = exit_ok;
endmodule
`default_nettype wire

// File: dhrs_sequencer_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module dhrs_sequencer_assertions #(
  parameter int unsigned REJECT_CYC = 4,
  parameter int unsigned CANCEL_IN_CYC = 50,
  parameter int unsigned CANCEL_OUT_CYC = 200
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hw_reset_in_n,
  input wire logic sleep_out_mode,
  input wire logic settings_store_valid,
  input wire logic settings_store_req,
  input wire logic reg_we,
  input wire logic restore_defaults,
  input wire dhrs_pkg::dhrs_status_t status,
  input wire logic cmd_accept,
  input wire logic sleep_exit_accept
);
  int lo;
  int hi;
  int t;
  logic so;
  // run lengths of the pin, and time since the defaults were restored
  always_ff @(posedge clk) begin
    lo <= hw_reset_in_n ? 0 : lo + 1;
    hi <= hw_reset_in_n ? hi + 1 : 0;
    t <= (!nrst || restore_defaults) ? 0 : t + 1;
    so <= status.blank ? so : sleep_out_mode;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  spike_reject_a: assert property ($rose(status.blank) |-> lo >= REJECT_CYC - 1)
    else $error("blanking began after a short low");
  glitch_hold_a: assert property ($rose(restore_defaults) |-> hi >= REJECT_CYC - 1)
    else $error("reset ended on a short high");
  load_start_a: assert property (restore_defaults |-> ##[1:2] settings_store_req)
    else $error("store fetch did not start");
  word_write_a: assert property (settings_store_valid && settings_store_req |-> ##[0:1] reg_we)
    else $error("stored word not written");
  blank_gate_a: assert property (status.blank |-> !cmd_accept && !sleep_exit_accept)
    else $error("gate open while blanked");
  cmd_open_a: assert property (t == CANCEL_IN_CYC + 16 |-> cmd_accept)
    else $error("command gate late");
  exit_open_a: assert property (t == CANCEL_OUT_CYC + 8 |-> sleep_exit_accept)
    else $error("sleep exit gate late");
  exit_wait_a: assert property ($rose(sleep_exit_accept) |-> t >= CANCEL_OUT_CYC - REJECT_CYC - 2)
    else $error("sleep exit gate early");
  cmd_wait_a: assert property ($rose(cmd_accept) && so |-> t >= CANCEL_IN_CYC - REJECT_CYC - 2)
    else $error("command gate early");
  pulse_once_a: assert property (restore_defaults |=> !restore_defaults)
    else $error("defaults pulse too long");
  cover property ($rose(cmd_accept));
  cover property ($rose(sleep_exit_accept));
  cover property (reg_we);
endmodule
bind dhrs_sequencer dhrs_sequencer_assertions #(.REJECT_CYC(REJECT_CYC),
  .CANCEL_IN_CYC(CANCEL_IN_CYC), .CANCEL_OUT_CYC(CANCEL_OUT_CYC)) u_chk (.clk(clk), .nrst(nrst),
  .hw_reset_in_n(hw_reset_in_n), .sleep_out_mode(sleep_out_mode),
  .settings_store_valid(settings_store_valid), .settings_store_req(settings_store_req),
  .reg_we(reg_we), .restore_defaults(restore_defaults), .status(status),
  .cmd_accept(cmd_accept), .sleep_exit_accept(sleep_exit_accept));
`default_nettype wire

// File: dhrs_store_model.sv
`timescale 1ns/1ns
`default_nettype none
module dhrs_store_model (
  input wire logic clk,
  input wire logic dly,
  input wire logic req,
  input wire logic [7:0] addr,
  output logic vld,
  output logic [7:0] dat
);
  logic [1:0] n;
  initial begin
    vld = 1'b0;
    dat = 8'h00;
    n = 2'h0;
  end
  // data wanders when not valid so a late sample shows up
  always @(posedge clk) begin
    vld <= 1'b0;
    dat <= ~dat;
    n <= (req && !vld) ? n + 2'h1 : 2'h0;
    if (req && !vld && n >= {1'b0, dly}) begin
      vld <= 1'b1;
      dat <= addr ^ 8'h5a;
    end
  end
endmodule
`default_nettype wire

// File: test_dhrs_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module test_dhrs_sequencer;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic pin = 1'b1;
  logic so = 1'b0;
  logic dly = 1'b0;
  logic vld, req, we, rd, ca, sa;
  logic [7:0] dat, addr, wd, wa;
  dhrs_pkg::dhrs_status_t st;
  logic [7:0] mem [16];
  int fails = 0;
  int checks_done = 0;
  int nrd = 0;
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    if (we) mem[wa[3:0]] <= wd;
    if (rd) nrd <= nrd + 1;
  end
  dhrs_sequencer #(.REJECT_CYC(4), .CANCEL_IN_CYC(50), .CANCEL_OUT_CYC(200), .BLANK_CYC(100))
    u_dhrs_sequencer (.clk(clk), .nrst(nrst), .hw_reset_in_n(pin), .sleep_out_mode(so),
    .settings_store_data(dat), .settings_store_valid(vld), .settings_store_addr(addr),
    .settings_store_req(req), .reg_wdata(wd), .reg_waddr(wa), .reg_we(we),
    .restore_defaults(rd), .status(st), .cmd_accept(ca), .sleep_exit_accept(sa));
  dhrs_store_model u_dhrs_store_model (.clk(clk), .dly(dly), .req(req), .addr(addr),
    .vld(vld), .dat(dat));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_words;
    for (int i = 0; i < 16; i++) chk(mem[i], 8'(i) ^ 8'h5a);
  endtask
  task automatic t_spike;
    nrd = 0;
    pin = 1'b0;
    cyc(3);
    pin = 1'b1;
    cyc(8);
    chk(st.blank, 1'b0);
    chk(8'(nrd), 8'h00);
  endtask
  task automatic t_reset(input logic s, input logic d);
    so = s;
    dly = d;
    nrd = 0;
    mem = '{default: 8'h00};
    pin = 1'b0;
    cyc(6);
    pin = 1'b1;
    cyc(2);
    pin = 1'b0;
    cyc(6);
    chk(st.blank, 1'b1);
    chk(ca, 1'b0);
    chk(st.busy, 1'b1);
    pin = 1'b1;
    cyc(8);
    chk(st.load_active, 1'b1);
    cyc(64);
    chk(8'(nrd), 8'h01);
    chk(ca, 1'b1);
    chk(st.ready, 1'b1);
    chk(st.busy, 1'b0);
    chk(st.load_active, 1'b0);
    chk(sa, 1'b0);
    t_words;
    cyc(140);
    chk(sa, 1'b1);
  endtask
  initial begin
    cyc(20);
    nrst = 1'b1;
    cyc(80);
    t_words;
    t_spike;
    t_reset(1'b1, 1'b0);
    t_reset(1'b0, 1'b1);
    wrap_up;
  end
  initial begin
    #20000;
    fails++;
    wrap_up;
  end
endmodule
`default_nettype wire
